// ### hdl/e1_line_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// framer-side digital pins of the quad line interface
interface e1_line_if;
   logic [3:0] tx_plus_mark;
   logic [3:0] tx_minus_mark;
   logic [3:0] tx_bit_clock;
   logic [3:0] rx_plus_mark;
   logic [3:0] rx_minus_mark;
   logic [3:0] signal_loss_flag;
   logic       loss_delay_select;
   logic       loss_timing_clock;

   modport device (
      input  tx_plus_mark, tx_minus_mark, tx_bit_clock,
      input  loss_delay_select, loss_timing_clock,
      output rx_plus_mark, rx_minus_mark, signal_loss_flag
   );
   modport framer (
      output tx_plus_mark, tx_minus_mark, tx_bit_clock,
      output loss_delay_select, loss_timing_clock,
      input  rx_plus_mark, rx_minus_mark, signal_loss_flag
   );
endinterface
`default_nettype wire

// ### hdl/e1_quad_device.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - four independent channels, no cross effects
// - each channel runs at 2.048 Mbps
// - select high standard, low extended timing
// - framer supplies timing clock only when extended
// - standard timing uses internal counts only
// - extended timing stretches declare and clear delays
// - loss flag held during loss condition
// - receive marks as two RZ rails
// - transmit accepts dual-rail NRZ or RZ
// - NRZ data retimed by transmit bit clock
module e1_quad_device (
   input  wire logic  i_clock,
   input  wire logic  i_nrst,
   e1_line_if.device  line,
   input  wire logic [3:0] i_line_in_plus,
   input  wire logic [3:0] i_line_in_minus,
   output logic [3:0] o_line_out_plus,
   output logic [3:0] o_line_out_minus
);
   // ==========================================================
   // shared pin synchronisers
   logic [1:0] sel_sync_reg;
   logic [2:0] ltc_sync_reg;
   wire        sel_standard;
   wire        ltc_tick;

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         sel_sync_reg <= 2'h3;
         ltc_sync_reg <= 3'h0;
      end else begin
         sel_sync_reg <= {sel_sync_reg[0], line.loss_delay_select};
         ltc_sync_reg <= {ltc_sync_reg[1:0], line.loss_timing_clock};
      end
   end

   // mode decode and timing clock rising edge
   assign sel_standard = (sel_sync_reg[1] == e1_quad_pkg::SEL_STANDARD);
   assign ltc_tick     = ltc_sync_reg[1] & ~ltc_sync_reg[2];

   // ==========================================================
   // one independent channel per lane
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++) begin : g_ch
         logic [1:0] txp_sync_reg;
         logic [1:0] txn_sync_reg;
         logic [2:0] txc_sync_reg;
         logic [1:0] rxp_sync_reg;
         logic [1:0] rxn_sync_reg;
         logic       txc_seen_reg;
         logic       outp_reg;
         logic       outn_reg;
         logic       rxp_reg;
         logic       rxn_reg;
         logic       flag_reg;
         logic [e1_quad_pkg::CNT_W-1:0] bitcnt_reg;
         logic [e1_quad_pkg::CNT_W-1:0] runcnt_reg;
         e1_quad_pkg::los_state_t state_reg;
         wire        txc_rise;
         wire        bit_tick;
         wire        mark_now;
         wire        step;
         wire [e1_quad_pkg::CNT_W-1:0] declare_lim;
         wire [e1_quad_pkg::CNT_W-1:0] clear_lim;

         // input synchronisers
         always_ff @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
               txp_sync_reg <= 2'h0;
               txn_sync_reg <= 2'h0;
               txc_sync_reg <= 3'h0;
               rxp_sync_reg <= 2'h0;
               rxn_sync_reg <= 2'h0;
            end else begin
               txp_sync_reg <= {txp_sync_reg[0], line.tx_plus_mark[ch]};
               txn_sync_reg <= {txn_sync_reg[0], line.tx_minus_mark[ch]};
               txc_sync_reg <= {txc_sync_reg[1:0], line.tx_bit_clock[ch]};
               rxp_sync_reg <= {rxp_sync_reg[0], i_line_in_plus[ch]};
               rxn_sync_reg <= {rxn_sync_reg[0], i_line_in_minus[ch]};
            end
         end

         assign txc_rise = txc_sync_reg[1] & ~txc_sync_reg[2];

         // transmit: clocked NRZ or pass-through RZ
         always_ff @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
               txc_seen_reg <= 1'b0;
               outp_reg     <= 1'b0;
               outn_reg     <= 1'b0;
            end else begin
               if (txc_rise) begin
                  txc_seen_reg <= 1'b1;
                  outp_reg     <= txp_sync_reg[1];
                  outn_reg     <= txn_sync_reg[1];
               end else if (!txc_seen_reg) begin
                  outp_reg     <= txp_sync_reg[1];
                  outn_reg     <= txn_sync_reg[1];
               end
            end
         end

         // receive: RZ marks re-registered, one rail per polarity
         always_ff @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
               rxp_reg <= 1'b0;
               rxn_reg <= 1'b0;
            end else begin
               rxp_reg <= rxp_sync_reg[1] & ~rxn_sync_reg[1];
               rxn_reg <= rxn_sync_reg[1] & ~rxp_sync_reg[1];
            end
         end

         // bit-period timer at the line rate
         always_ff @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
               bitcnt_reg <= e1_quad_pkg::CNT_ZERO;
            end else if (bitcnt_reg == e1_quad_pkg::CNT_W'(e1_quad_pkg::BIT_CYCLES - 1)) begin
               bitcnt_reg <= e1_quad_pkg::CNT_ZERO;
            end else begin
               bitcnt_reg <= bitcnt_reg + e1_quad_pkg::CNT_ONE;
            end
         end

         assign bit_tick    = (bitcnt_reg == e1_quad_pkg::CNT_W'(e1_quad_pkg::BIT_CYCLES - 1));
         assign mark_now    = rxp_reg | rxn_reg;
         // step source and limits per mode
         assign step        = sel_standard ? bit_tick : ltc_tick;
         assign declare_lim = sel_standard ? e1_quad_pkg::CNT_W'(e1_quad_pkg::STD_DECLARE_ZEROS)
                                           : e1_quad_pkg::CNT_W'(e1_quad_pkg::EXT_DECLARE_TICKS);
         assign clear_lim   = sel_standard ? e1_quad_pkg::CNT_W'(e1_quad_pkg::STD_CLEAR_MARKS)
                                           : e1_quad_pkg::CNT_W'(e1_quad_pkg::EXT_CLEAR_TICKS);

         // mark capture across one step period (line bit or timing clock)
         logic mark_seen_reg;
         always_ff @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
               mark_seen_reg <= 1'b0;
            end else if (step) begin
               mark_seen_reg <= mark_now;
            end else if (mark_now) begin
               mark_seen_reg <= 1'b1;
            end
         end

         // loss declare and clear sequencing
         always_ff @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
               state_reg  <= e1_quad_pkg::LOS_OK;
               runcnt_reg <= e1_quad_pkg::CNT_ZERO;
               flag_reg   <= 1'b0;
            end else if (step) begin
               case (state_reg)
                  e1_quad_pkg::LOS_OK: begin
                     runcnt_reg <= e1_quad_pkg::CNT_ONE;
                     if (!mark_seen_reg) state_reg <= e1_quad_pkg::LOS_DECLARE;
                  end
                  e1_quad_pkg::LOS_DECLARE: begin
                     if (mark_seen_reg) begin
                        state_reg <= e1_quad_pkg::LOS_OK;
                     end else if (runcnt_reg >= declare_lim - e1_quad_pkg::CNT_ONE) begin
                        state_reg <= e1_quad_pkg::LOS_LOST;
                        flag_reg  <= 1'b1;
                     end else begin
                        runcnt_reg <= runcnt_reg + e1_quad_pkg::CNT_ONE;
                     end
                  end
                  e1_quad_pkg::LOS_LOST: begin
                     runcnt_reg <= e1_quad_pkg::CNT_ONE;
                     if (mark_seen_reg) state_reg <= e1_quad_pkg::LOS_CLEAR;
                  end
                  e1_quad_pkg::LOS_CLEAR: begin
                     if (!mark_seen_reg) begin
                        state_reg <= e1_quad_pkg::LOS_LOST;
                     end else if (runcnt_reg >= clear_lim - e1_quad_pkg::CNT_ONE) begin
                        state_reg <= e1_quad_pkg::LOS_OK;
                        flag_reg  <= 1'b0;
                     end else begin
                        runcnt_reg <= runcnt_reg + e1_quad_pkg::CNT_ONE;
                     end
                  end
                  default: begin
                     state_reg <= e1_quad_pkg::LOS_OK;
                  end
               endcase
            end
         end

         assign o_line_out_plus[ch]       = outp_reg;
         assign o_line_out_minus[ch]      = outn_reg;
         assign line.rx_plus_mark[ch]     = rxp_reg;
         assign line.rx_minus_mark[ch]    = rxn_reg;
         assign line.signal_loss_flag[ch] = flag_reg;
      end
   endgenerate
endmodule
`default_nettype wire

// ### hdl/e1_quad_framer.sv
`timescale 1ns/1ps
`default_nettype none
module e1_quad_framer (
   input  wire logic       i_clock,
   input  wire logic       i_nrst,
   e1_line_if.framer       line,
   input  wire logic [3:0] i_send_plus,
   input  wire logic [3:0] i_send_minus,
   input  wire logic [3:0] i_use_nrz,
   input  wire logic       i_extended,
   output logic [3:0]      o_bit_strobe,
   output logic [3:0]      o_got_plus,
   output logic [3:0]      o_got_minus,
   output logic [3:0]      o_loss
);
   // ==========================================================
   // bit timer and loss-timing clock divider
   logic [7:0] bitcnt_reg;
   logic [7:0] ltccnt_reg;
   logic       ltc_reg;
   logic [3:0] txp_reg;
   logic [3:0] txn_reg;
   logic [3:0] txc_reg;
   logic [1:0] los_sync_reg [4];
   logic [1:0] rxp_sync_reg [4];
   logic [1:0] rxn_sync_reg [4];
   wire        bit_end;
   wire        half_bit;

   assign bit_end  = (bitcnt_reg == 8'(e1_quad_pkg::BIT_CYCLES - 1));
   assign half_bit = (bitcnt_reg == 8'(e1_quad_pkg::HALF_BIT_CYCLES));

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         bitcnt_reg <= 8'h00;
         ltccnt_reg <= 8'h00;
         ltc_reg    <= 1'b0;
      end else begin
         bitcnt_reg <= bit_end ? 8'h00 : bitcnt_reg + 8'h01;
         ltccnt_reg <= ltccnt_reg + 8'h01;
         // clock only in extended mode, held low otherwise
         ltc_reg    <= i_extended & ltccnt_reg[7];
      end
   end

   // transmit rails: NRZ held whole bit with clock, RZ half bit
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         txp_reg <= 4'h0;
         txn_reg <= 4'h0;
         txc_reg <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (bit_end) begin
               txp_reg[i] <= i_send_plus[i];
               txn_reg[i] <= i_send_minus[i] & ~i_send_plus[i];
               txc_reg[i] <= 1'b0;
            end else if (half_bit) begin
               txc_reg[i] <= i_use_nrz[i];
               if (!i_use_nrz[i]) begin
                  txp_reg[i] <= 1'b0;
                  txn_reg[i] <= 1'b0;
               end
            end
         end
      end
   end

   // receive side synchronisers
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int i = 0; i < 4; i++) begin
            los_sync_reg[i] <= 2'h0;
            rxp_sync_reg[i] <= 2'h0;
            rxn_sync_reg[i] <= 2'h0;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            los_sync_reg[i] <= {los_sync_reg[i][0], line.signal_loss_flag[i]};
            rxp_sync_reg[i] <= {rxp_sync_reg[i][0], line.rx_plus_mark[i]};
            rxn_sync_reg[i] <= {rxn_sync_reg[i][0], line.rx_minus_mark[i]};
         end
      end
   end

   // user outputs from synchronised flops
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         o_loss[i]      = los_sync_reg[i][1];
         o_got_plus[i]  = rxp_sync_reg[i][1];
         o_got_minus[i] = rxn_sync_reg[i][1];
      end
   end

   assign o_bit_strobe           = {4{bit_end}};
   assign line.tx_plus_mark      = txp_reg;
   assign line.tx_minus_mark     = txn_reg;
   assign line.tx_bit_clock      = txc_reg;
   assign line.loss_timing_clock = ltc_reg;
   // select high chooses standard timing
   assign line.loss_delay_select = i_extended ? e1_quad_pkg::SEL_EXTENDED
                                              : e1_quad_pkg::SEL_STANDARD;
endmodule
`default_nettype wire

// ### hdl/e1_quad_pkg.sv
`default_nettype none
package e1_quad_pkg;
   // ==========================================================
   // channel count and line timing
   localparam int unsigned CHANNELS        = 4;
   localparam int unsigned CLOCK_HZ        = 50_000_000;
   localparam int unsigned LINE_BPS        = 2_048_000;
   // cycles of i_clock per line bit, rounded down
   localparam int unsigned BIT_CYCLES      = CLOCK_HZ / LINE_BPS;
   localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
   // ==========================================================
   // standard loss-of-signal timing, in line bit periods
   localparam int unsigned STD_DECLARE_ZEROS = 32;
   localparam int unsigned STD_CLEAR_MARKS   = 32;
   // extended timing, in loss-timing clock periods (implementer choice)
   localparam int unsigned EXT_DECLARE_TICKS = 16;
   localparam int unsigned EXT_CLEAR_TICKS   = 16;
   // ==========================================================
   // select pin levels
   localparam logic SEL_STANDARD = 1'b1;
   localparam logic SEL_EXTENDED = 1'b0;
   // ==========================================================
   // counter width used by the timers
   localparam int unsigned CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
   // ==========================================================
   // per-channel loss state
   typedef enum logic [1:0] {LOS_OK, LOS_DECLARE, LOS_LOST, LOS_CLEAR} los_state_t;
endpackage
`default_nettype wire

// ### verification/e1_quad_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// interface checker for the framer to device link
module e1_quad_assertions (
   input  wire logic       i_clock,
   input  wire logic       i_nrst,
   input  wire logic [3:0] i_tx_plus_mark,
   input  wire logic [3:0] i_tx_minus_mark,
   input  wire logic [3:0] i_tx_bit_clock,
   input  wire logic [3:0] i_rx_plus_mark,
   input  wire logic [3:0] i_rx_minus_mark,
   input  wire logic [3:0] i_signal_loss_flag,
   input  wire logic       i_loss_delay_select,
   input  wire logic       i_loss_timing_clock
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   // ==========================================================
   // timing clock phases
   sequence s_tick_high;
      i_loss_timing_clock [*8];
   endsequence
   sequence s_tick_low;
      (!i_loss_timing_clock) [*8];
   endsequence

   a_timing_clock_idle: assert property (
      i_loss_delay_select == e1_quad_pkg::SEL_STANDARD |-> !i_loss_timing_clock)
      else $error("timing clock runs in standard mode");
   a_tick_high_wide: assert property ($rose(i_loss_timing_clock) |-> s_tick_high)
      else $error("timing clock high phase too short");
   a_tick_low_wide: assert property ($fell(i_loss_timing_clock) |-> s_tick_low)
      else $error("timing clock low phase too short");

   // ==========================================================
   // per channel quiet counters and loss checks
   genvar k;
   for (k = 0; k < 4; k++) begin : g_ch
      logic [12:0] quiet_reg;
      logic [12:0] quiet_next;
      wire         mark_seen = i_rx_plus_mark[k] | i_rx_minus_mark[k];
      wire         std_mode  = i_loss_delay_select == e1_quad_pkg::SEL_STANDARD;
      // saturating count of cycles since the last receive mark
      assign quiet_next = mark_seen ? 13'h0000 : ((&quiet_reg) ? quiet_reg : quiet_reg + 13'h0001);
      always_ff @(posedge i_clock or negedge i_nrst) begin
         if (!i_nrst) begin
            quiet_reg <= 13'h0000;
         end else begin
            quiet_reg <= quiet_next;
         end
      end
      a_no_double_mark: assert property (
         !(i_rx_plus_mark[k] && i_rx_minus_mark[k]))
         else $error("both receive rails high");
      a_declare_not_early: assert property (
         $rose(i_signal_loss_flag[k]) && std_mode |-> quiet_reg >= 13'h02bc)
         else $error("loss declared too early");
      a_ext_not_early: assert property (
         $rose(i_signal_loss_flag[k]) && !std_mode |-> quiet_reg >= 13'h0dac)
         else $error("extended loss declared too early");
      a_std_deadline: assert property (
         std_mode && quiet_reg == 13'h0384 |-> i_signal_loss_flag[k])
         else $error("loss not declared in time");
      a_ext_deadline: assert property (
         !std_mode && quiet_reg == 13'h157c |-> i_signal_loss_flag[k])
         else $error("extended loss not declared");
      a_flag_holds: assert property (
         i_signal_loss_flag[k] && quiet_reg >= 13'h003c |=> i_signal_loss_flag[k])
         else $error("loss flag dropped while quiet");
      a_clear_needs_marks: assert property (
         $fell(i_signal_loss_flag[k]) |-> quiet_reg < 13'h003c)
         else $error("loss cleared without marks");
      a_nrz_rails_stable: assert property (
         i_tx_bit_clock[k] && $past(i_tx_bit_clock[k])
         |-> $stable(i_tx_plus_mark[k]) && $stable(i_tx_minus_mark[k]))
         else $error("transmit rails moved while clock high");
   end
endmodule
`default_nettype wire

// ### verification/test_quad_e1_line_digital_side.sv
`timescale 1ns/1ps
`default_nettype none
module test_quad_e1_line_digital_side;
   logic       i_clock  = 1'b0;
   logic       i_nrst   = 1'b0;
   logic [3:0] send_p   = 4'h0;
   logic [3:0] send_m   = 4'h0;
   logic [3:0] use_nrz  = 4'h0;
   logic       extended = 1'b0;
   logic [3:0] feed     = 4'h7;
   logic [3:0] line_p   = 4'h0;
   logic [3:0] line_m   = 4'h0;
   logic [4:0] phase    = 5'h00;
   logic       sign     = 1'b0;
   logic       tick_q   = 1'b0;
   int         errors   = 0;
   int         comparisons = 0;
   int         cycles   = 0;
   int         ticks    = 0;
   int         start;
   // expected loss delays, in clocks or timing clock ticks
   localparam int STD_DECL_CYC   = int'(e1_quad_pkg::STD_DECLARE_ZEROS * e1_quad_pkg::BIT_CYCLES);
   localparam int STD_CLR_CYC    = int'(e1_quad_pkg::STD_CLEAR_MARKS * e1_quad_pkg::BIT_CYCLES);
   localparam int EXT_DECL_TICKS = int'(e1_quad_pkg::EXT_DECLARE_TICKS);
   localparam int EXT_CLR_TICKS  = int'(e1_quad_pkg::EXT_CLEAR_TICKS);
   logic [3:0] out_p, out_m, got_p, got_m, loss, strobe;
   e1_line_if  line ();
   wire  [6:0] probe = {strobe[0], loss[3], line.tx_bit_clock[1], got_m[0], got_p[0],
                        out_m[1], out_p[0]};

   e1_quad_framer e1_quad_framer_inst (.i_clock(i_clock), .i_nrst(i_nrst), .line(line),
      .i_send_plus(send_p), .i_send_minus(send_m), .i_use_nrz(use_nrz), .i_extended(extended),
      .o_bit_strobe(strobe), .o_got_plus(got_p), .o_got_minus(got_m), .o_loss(loss));
   e1_quad_device e1_quad_device_inst (.i_clock(i_clock), .i_nrst(i_nrst), .line(line),
      .i_line_in_plus(line_p), .i_line_in_minus(line_m),
      .o_line_out_plus(out_p), .o_line_out_minus(out_m));
   e1_quad_assertions e1_quad_assertions_inst (.i_clock(i_clock), .i_nrst(i_nrst),
      .i_tx_plus_mark(line.tx_plus_mark), .i_tx_minus_mark(line.tx_minus_mark),
      .i_tx_bit_clock(line.tx_bit_clock), .i_rx_plus_mark(line.rx_plus_mark),
      .i_rx_minus_mark(line.rx_minus_mark), .i_signal_loss_flag(line.signal_loss_flag),
      .i_loss_delay_select(line.loss_delay_select),
      .i_loss_timing_clock(line.loss_timing_clock));

   always #10 i_clock = ~i_clock;

   // ==========================================================
   // alternate mark line source, one half-bit pulse per 24 clocks
   always @(posedge i_clock) begin
      phase  <= (phase == 5'h17) ? 5'h00 : phase + 5'h01;
      sign   <= (phase == 5'h17) ? ~sign : sign;
      line_p <= (phase < 5'h0c) ? (feed & {4{~sign}}) : 4'h0;
      line_m <= (phase < 5'h0c) ? (feed & {4{sign}}) : 4'h0;
      tick_q <= line.loss_timing_clock;
      ticks  <= ticks + int'(line.loss_timing_clock & ~tick_q);
      cycles <= cycles + 1;
   end

   task check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   // wait mid-cycle for a probe bit, bounded
   task wait_probe(input int idx, input logic val, input int limit);
      int n;
      n = 0;
      while (probe[idx] !== val && n < limit) begin
         @(negedge i_clock);
         n++;
      end
   endtask

   task give_verdict;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge i_clock);
      errors++;
      give_verdict();
   end

   initial begin
      repeat (16) @(posedge i_clock);
      i_nrst <= 1'b1;
      start  = cycles;
      send_p <= 4'h1;
      wait_probe(0, 1'b1, 200);
      check("rz line out plus", out_p, 4'h1);
      check("rz line out minus", out_m, 4'h0);
      @(posedge i_clock);
      send_p <= 4'h0;
      $display("test rz transmit done");
      use_nrz <= 4'h2;
      send_m  <= 4'h2;
      wait_probe(4, 1'b1, 200);
      check("nrz bit clock", {3'h0, probe[4]}, 4'h1);
      wait_probe(1, 1'b1, 200);
      check("nrz line out minus", out_m & 4'he, 4'h2);
      check("nrz line out plus", out_p & 4'he, 4'h0);
      $display("test nrz transmit done");
      // bit strobe: all lanes together, once per line bit, one clock wide
      wait_probe(6, 1'b1, 30);
      check("bit strobe", strobe, 4'hf);
      repeat (e1_quad_pkg::BIT_CYCLES) @(negedge i_clock);
      check("bit strobe period", strobe, 4'hf);
      @(negedge i_clock);
      check("bit strobe width", strobe, 4'h0);
      $display("test bit strobe done");
      wait_probe(2, 1'b1, 100);
      check("rx plus mark", {3'h0, got_p[0]}, 4'h1);
      wait_probe(3, 1'b1, 100);
      check("rx minus mark", {3'h0, got_m[0]}, 4'h1);
      check("quiet channel marks", {line.rx_plus_mark[3], line.rx_minus_mark[3], 2'h0}, 4'h0);
      $display("test receive done");
      wait_probe(5, 1'b1, 2000);
      check("standard loss", loss, 4'h8);
      check("loss flag pins", line.signal_loss_flag, 4'h8);
      check("standard declare delay", {3'h0, cycles - start >= STD_DECL_CYC}, 4'h1);
      @(posedge i_clock);
      start = cycles;
      feed  <= 4'hf;
      wait_probe(5, 1'b0, 2000);
      check("standard clear", loss, 4'h0);
      check("standard clear delay", {3'h0, cycles - start >= STD_CLR_CYC}, 4'h1);
      $display("test standard loss done");
      @(posedge i_clock);
      extended <= 1'b1;
      i_nrst   <= 1'b0;
      feed     <= 4'h7;
      repeat (16) @(posedge i_clock);
      i_nrst <= 1'b1;
      @(negedge i_clock);
      start = ticks;
      check("select level", {3'h0, line.loss_delay_select}, {3'h0, e1_quad_pkg::SEL_EXTENDED});
      wait_probe(5, 1'b1, 8000);
      check("extended loss", loss, 4'h8);
      check("extended declare ticks", {3'h0, ticks - start >= EXT_DECL_TICKS}, 4'h1);
      @(posedge i_clock);
      start = ticks;
      feed  <= 4'hf;
      wait_probe(5, 1'b0, 8000);
      check("extended clear", loss, 4'h0);
      check("extended clear ticks", {3'h0, ticks - start >= EXT_CLR_TICKS}, 4'h1);
      $display("test extended loss done");
      give_verdict();
   end
endmodule
`default_nettype wire
